// file: logic/cfg_chain_pkg.sv
// constants and types shared by both ends of the serial clock-config chain
// assumes a single 25 MHz core clock on both ends
package cfg_chain_pkg;
   localparam int CHAIN_LEN = 81;
   localparam int CLK_PERIOD_NS = 40;
   // shift clock is core clock divided by this many cycles per half period
   localparam int SHIFT_HALF_CYCLES = 2;
   // field positions, lsb of each field
   localparam int POS_INPUT_DIV = 0;
   localparam int POS_FEEDBACK_DIV = 7;
   localparam int POS_OUT_DIV_A = 14;
   localparam int POS_OUT_DIV_B = 19;
   localparam int POS_OUT_DIV_C = 24;
   localparam int POS_MUX_A = 29;
   localparam int POS_MUX_B = 32;
   localparam int POS_MUX_C = 35;
   localparam int POS_FB_SELECT = 38;
   localparam int POS_FB_DELAY = 40;
   localparam int POS_FB_EXTRA = 45;
   localparam int POS_GLOBAL_A_DLY = 46;
   localparam int POS_GLOBAL_B_DLY = 51;
   localparam int POS_GLOBAL_C_DLY = 56;
   localparam int POS_CORE_B_DLY = 61;
   localparam int POS_CORE_C_DLY = 66;
   localparam int POS_STATIC_SEL_A = 71;
   localparam int POS_STATIC_SEL_B = 72;
   localparam int POS_STATIC_SEL_C = 73;
   localparam int POS_VCO_RANGE = 74;
   localparam int POS_DYN_SEL_A = 77;
   localparam int POS_DYN_SEL_B = 78;
   localparam int POS_DYN_SEL_C = 79;
   localparam int POS_RESET_PERMIT = 80;
   // bits the simulation model treats as don't care
   localparam logic [CHAIN_LEN-1:0] SIM_IGNORE_MASK =
      81'h0_0000_0000_0000_0000_0000 | (81'h7 << 71) | (81'h7 << 77);
   // default nonvolatile image: all dividers /1, reset permit set
   localparam logic [CHAIN_LEN-1:0] NV_DEFAULT_IMAGE =
      81'h1_0000_0000_0000_0000_0000;
   typedef enum logic [1:0] {
      CTL_IDLE = 2'b00,
      CTL_SHIFT = 2'b01,
      CTL_GAP = 2'b10,
      CTL_UPDATE = 2'b11
   } ctl_state_t;
endpackage

// file: logic/cfg_chain_if.sv
// serial configuration link between controller and clock block
// the controller makes the shift clock as a one-cycle enable pulse
`timescale 1ns/1ps
interface cfg_chain_if;
   logic shift_clk_en;
   logic config_shift_enable;
   logic config_update;
   logic serial_config_in;
   logic serial_config_out;
   logic block_power_off_n;
   logic config_source_dynamic;
   modport device (
      input shift_clk_en, config_shift_enable, config_update,
      input serial_config_in, block_power_off_n, config_source_dynamic,
      output serial_config_out
   );
   modport controller (
      output shift_clk_en, config_shift_enable, config_update,
      output serial_config_in, block_power_off_n, config_source_dynamic,
      input serial_config_out
   );
endinterface

// file: logic/cfg_field_decode.sv
// splits an active configuration word into its named fields
// purely combinational, fed by the clock block's applied word
`timescale 1ns/1ps
module cfg_field_decode
   import cfg_chain_pkg::*;
(
   input wire logic [CHAIN_LEN-1:0] i_word,
   output logic [6:0] o_input_divider,
   output logic [6:0] o_feedback_divider,
   output logic [14:0] o_output_dividers,
   output logic [8:0] o_post_pll_selects,
   output logic [1:0] o_feedback_select,
   output logic [4:0] o_feedback_delay,
   output logic o_feedback_extra_select,
   output logic [24:0] o_output_delays,
   output logic [2:0] o_static_input_selects,
   output logic [2:0] o_vco_range_select,
   output logic [2:0] o_dynamic_input_selects,
   output logic o_reset_permit_bit
);
   // field slicing by the package layout [RULE_11] [RULE_12]
   assign o_input_divider = i_word[POS_INPUT_DIV +: 7];
   assign o_feedback_divider = i_word[POS_FEEDBACK_DIV +: 7];
   assign o_output_dividers = i_word[POS_OUT_DIV_A +: 15];
   assign o_post_pll_selects = i_word[POS_MUX_A +: 9];
   assign o_feedback_select = i_word[POS_FB_SELECT +: 2];
   assign o_feedback_delay = i_word[POS_FB_DELAY +: 5];
   assign o_feedback_extra_select = i_word[POS_FB_EXTRA];
   assign o_output_delays = i_word[POS_GLOBAL_A_DLY +: 25];
   assign o_static_input_selects = i_word[POS_STATIC_SEL_A +: 3]; // [RULE_14]
   assign o_vco_range_select = i_word[POS_VCO_RANGE +: 3]; // [RULE_13]
   assign o_dynamic_input_selects = i_word[POS_DYN_SEL_A +: 3];
   assign o_reset_permit_bit = i_word[POS_RESET_PERMIT];
endmodule

// file: logic/clock_cfg_block.sv
// device end: 81-bit shift chain, update latch and active configuration
// assumes controller drives the link on the same core clock
`timescale 1ns/1ps
module clock_cfg_block
   import cfg_chain_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   cfg_chain_if.device link,
   output logic o_block_enabled,
   output logic o_dynamic_mode,
   output logic o_lock_held,
   output logic [6:0] o_input_divider,
   output logic [6:0] o_feedback_divider,
   output logic [14:0] o_output_dividers,
   output logic [8:0] o_post_pll_selects,
   output logic [1:0] o_feedback_select,
   output logic [4:0] o_feedback_delay,
   output logic o_feedback_extra_select,
   output logic [24:0] o_output_delays,
   output logic [2:0] o_static_input_selects,
   output logic [2:0] o_vco_range_select,
   output logic [2:0] o_dynamic_input_selects,
   output logic o_reset_permit_bit,
   output logic o_secondary_from_pins
);
   logic [CHAIN_LEN-1:0] chain_reg;
   logic [CHAIN_LEN-1:0] active_reg;
   logic [CHAIN_LEN-1:0] applied_word;
   logic lock_reg;
   logic [13:0] ref_fields;

   // shift chain advances one place per shift-clock enable [RULE_19] [RULE_06]
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         chain_reg <= '0;
      end else if (link.shift_clk_en && link.config_shift_enable) begin
         chain_reg <= {link.serial_config_in, chain_reg[CHAIN_LEN-1:1]};
      end
   end

   // chain end reads back to the controller [RULE_18]
   assign link.serial_config_out = chain_reg[0];

   // update latch: level-sensitive on update, ignores the shift clock;
   // chain itself is left untouched [RULE_04] [RULE_20]
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         active_reg <= NV_DEFAULT_IMAGE; // [RULE_02]
      end else if (link.config_update) begin
         active_reg <= chain_reg;
      end
   end

   // lock kept unless input divider or feedback divider fields change [RULE_03]
   assign ref_fields = chain_reg[POS_INPUT_DIV +: 14];
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lock_reg <= 1'b1;
      end else if (link.config_update && link.config_source_dynamic) begin
         lock_reg <= (ref_fields == active_reg[POS_INPUT_DIV +: 14]);
      end else if (!link.config_update) begin
         lock_reg <= 1'b1;
      end
   end

   // static mode uses nonvolatile image, dynamic the loaded one [RULE_16]
   // powered off block presents an all-zero word [RULE_15] [RULE_01]
   always_comb begin
      if (!link.block_power_off_n) begin
         applied_word = '0;
      end else if (link.config_source_dynamic) begin
         applied_word = active_reg & ~SIM_IGNORE_MASK; // [RULE_08]
      end else begin
         applied_word = NV_DEFAULT_IMAGE;
      end
   end

   assign o_block_enabled = link.block_power_off_n;
   assign o_dynamic_mode = link.config_source_dynamic;
   assign o_lock_held = lock_reg & link.block_power_off_n;
   // secondary pins reach outputs only when the second post-pll select, bits 5:3,
   // is bypass (code 0); a reading, since the exact bypass code is not fixed [RULE_17]
   assign o_secondary_from_pins = (o_post_pll_selects[5:3] == 3'h0) &&
      link.block_power_off_n;

   // field decode; the 74+6 field split is only a layout fact [RULE_10]
   cfg_field_decode u_decode (
      .i_word(applied_word),
      .o_input_divider(o_input_divider),
      .o_feedback_divider(o_feedback_divider),
      .o_output_dividers(o_output_dividers),
      .o_post_pll_selects(o_post_pll_selects),
      .o_feedback_select(o_feedback_select),
      .o_feedback_delay(o_feedback_delay),
      .o_feedback_extra_select(o_feedback_extra_select),
      .o_output_delays(o_output_delays),
      .o_static_input_selects(o_static_input_selects),
      .o_vco_range_select(o_vco_range_select),
      .o_dynamic_input_selects(o_dynamic_input_selects),
      .o_reset_permit_bit(o_reset_permit_bit)
   );
endmodule

// file: logic/clock_cfg_controller.sv
// controller end: AHB-Lite slave that shifts an 81-bit word into the block
// assumes one AHB-Lite master, single word transfers, core clock only
`timescale 1ns/1ps

// Behaviour
// [RULE_01] config bits choose dividers, muxes, power
// [RULE_02] nonvolatile image is default until reload
// [RULE_03] keeping divider and feedback keeps lock
// [RULE_04] update latch independent of shift clock
// [RULE_05] update low while shift enable high
// [RULE_06] full load is 81 serial bits
// [RULE_07] after last bit: drop shift, then update
// [RULE_08] bits 71-73, 77-79 ignored in simulation
// [RULE_09] final reset-permit bit always loaded as one
// [RULE_10] 74 bits known, six after layout
// [RULE_11] word holds input, feedback, three output dividers
// [RULE_12] word holds muxes, feedback selects, delays
// [RULE_13] 3-bit vco field picks range
// [RULE_14] static and dynamic select per input
// [RULE_15] power input low switches block off
// [RULE_16] source input: low static, high dynamic
// [RULE_17] secondary inputs matter only in bypass
// [RULE_18] chain end drives serial output
// [RULE_19] each enabled shift edge moves one place
// [RULE_20] update copies chain, chain unchanged
module clock_cfg_controller
   import cfg_chain_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   cfg_chain_if.controller link
);
   // register map: word0..2 data, ctrl, status, readback0..2
   localparam logic [7:0] ADDR_WORD0 = 8'h00;
   localparam logic [7:0] ADDR_WORD1 = 8'h04;
   localparam logic [7:0] ADDR_WORD2 = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_RBACK0 = 8'h14;
   localparam logic [7:0] ADDR_RBACK1 = 8'h18;
   localparam logic [7:0] ADDR_RBACK2 = 8'h1c;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // last divider count of one shift period, one tick per full period
   localparam logic [1:0] TICK_LAST = 2'(2 * SHIFT_HALF_CYCLES - 1);

   ctl_state_t state_reg;
   logic [95:0] word_reg;
   logic [95:0] word_next;
   logic [1:0] ctrl_next;
   logic busy;
   logic [CHAIN_LEN-1:0] load_reg;
   logic [CHAIN_LEN-1:0] rback_reg;
   logic [6:0] count_reg;
   logic [1:0] div_reg;
   logic [1:0] ctrl_reg;
   logic start_pulse;
   logic tick;
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic addr_valid;

   // single-cycle address phase capture; slave never stalls
   assign addr_valid = i_hsel && i_hready && i_htrans[1];
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else if (i_hready) begin
         wr_pend_reg <= addr_valid && i_hwrite;
         addr_reg <= i_haddr[7:0];
      end
   end
   // no wait states and no error responses: every access is one cycle
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // register values after this edge's data phase write; reads use them
   // too, so a read right behind a write never returns the stale word
   always_comb begin
      word_next = word_reg;
      ctrl_next = ctrl_reg;
      if (wr_pend_reg) begin
         case (addr_reg)
            ADDR_WORD0: word_next[31:0] = i_hwdata;
            ADDR_WORD1: word_next[63:32] = i_hwdata;
            ADDR_WORD2: word_next[95:64] = i_hwdata;
            ADDR_CTRL: ctrl_next = i_hwdata[1:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   // data phase writes land here; word bit 80 is forced on load [RULE_09]
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         word_reg <= '0;
         ctrl_reg <= CTRL_RESET;
      end else begin
         word_reg <= word_next;
         ctrl_reg <= ctrl_next;
      end
   end
   assign start_pulse = wr_pend_reg && (addr_reg == ADDR_STATUS) &&
      i_hwdata[0] && (state_reg == CTL_IDLE);
   // a start accepted at this edge already reads back as busy
   assign busy = (state_reg != CTL_IDLE) || start_pulse;

   // read data registered at address phase, from the post-write values
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (addr_valid && !i_hwrite) begin
         case (i_haddr[7:0])
            ADDR_WORD0: o_hrdata <= word_next[31:0];
            ADDR_WORD1: o_hrdata <= word_next[63:32];
            ADDR_WORD2: o_hrdata <= {15'h0000, word_next[80:64]};
            ADDR_CTRL: o_hrdata <= {30'h0, ctrl_next};
            ADDR_STATUS: o_hrdata <= {31'h0, busy};
            ADDR_RBACK0: o_hrdata <= rback_reg[31:0];
            ADDR_RBACK1: o_hrdata <= rback_reg[63:32];
            ADDR_RBACK2: o_hrdata <= {15'h0000, rback_reg[80:64]};
            default: o_hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // shift clock enable divider; runs only while shifting
   always_ff @(posedge i_core_clk) begin
      if (i_rst || state_reg != CTL_SHIFT) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign tick = (state_reg == CTL_SHIFT) && (div_reg == TICK_LAST);

   // sequencer: shift 81 bits, gap, then one update cycle [RULE_06] [RULE_07]
   // the gap cycle keeps update clear of the last shift edge
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_reg <= CTL_IDLE;
      end else begin
         case (state_reg)
            CTL_IDLE: begin
               if (start_pulse) begin
                  state_reg <= CTL_SHIFT;
               end
            end
            CTL_SHIFT: begin
               if (tick && count_reg == 7'(CHAIN_LEN - 1)) begin
                  state_reg <= CTL_GAP;
               end
            end
            CTL_GAP: state_reg <= CTL_UPDATE;
            CTL_UPDATE: state_reg <= CTL_IDLE;
            default: state_reg <= CTL_IDLE;
         endcase
      end
   end

   // bits sent so far in this load
   always_ff @(posedge i_core_clk) begin
      if (i_rst || start_pulse) begin
         count_reg <= 7'h00;
      end else if (tick) begin
         count_reg <= count_reg + 7'h01;
      end
   end

   // outgoing word, lsb first; bit 80 always goes out as one [RULE_09]
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         load_reg <= '0;
      end else if (start_pulse) begin
         load_reg <= {1'b1, word_reg[79:0]};
      end else if (tick) begin
         load_reg <= {1'b0, load_reg[CHAIN_LEN-1:1]};
      end
   end

   // old chain contents come back out as the new word goes in [RULE_18]
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rback_reg <= '0;
      end else if (tick) begin
         rback_reg <= {link.serial_config_out, rback_reg[CHAIN_LEN-1:1]};
      end
   end

   // update only outside shift, so the two never overlap [RULE_05]
   assign link.shift_clk_en = tick;
   assign link.config_shift_enable = (state_reg == CTL_SHIFT);
   assign link.config_update = (state_reg == CTL_UPDATE);
   assign link.serial_config_in = load_reg[0];
   // power and source are plain register levels, never pulsed
   assign link.block_power_off_n = ctrl_reg[0]; // [RULE_15]
   assign link.config_source_dynamic = ctrl_reg[1]; // [RULE_16]
endmodule

// file: verif/pll_serial_config_chain_sva.sv
// link checker for the serial clock-config chain
// assumes one core clock, synchronous active-high reset, used beside the link
`timescale 1ns/1ps
module pll_serial_config_chain_sva
   import cfg_chain_pkg::*;
(
   input logic i_core_clk,
   input logic i_rst,
   input logic shift_clk_en,
   input logic config_shift_enable,
   input logic config_update,
   input logic serial_config_in,
   input logic serial_config_out,
   input logic block_power_off_n,
   input logic config_source_dynamic
);
   int cyc_reg;
   int tick_reg;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // counts of one shift burst, read at the cycle shift enable drops
   always_ff @(posedge i_core_clk) begin
      if (i_rst || !config_shift_enable) begin
         cyc_reg <= 0;
         tick_reg <= 0;
      end else begin
         cyc_reg <= cyc_reg + 1;
         if (shift_clk_en) begin
            tick_reg <= tick_reg + 1;
         end
      end
   end
   // a shift cut short by reset is not a finished load
   AST_UPD_NOT_IN_SHIFT: assert property (
      config_update |-> !config_shift_enable)
      else $error("update during shift");
   AST_UPD_AFTER_GAP: assert property (
      $fell(config_shift_enable) && !$past(i_rst)
      |-> !config_update ##1 config_update)
      else $error("update not after gap");
   AST_UPD_ONE_CYCLE: assert property (
      config_update |=> !config_update)
      else $error("update longer than one cycle");
   AST_SHIFT_LENGTH: assert property (
      $fell(config_shift_enable) && !$past(i_rst)
      |-> cyc_reg == CHAIN_LEN * 2 * SHIFT_HALF_CYCLES)
      else $error("shift length wrong");
   AST_TICK_COUNT: assert property (
      $fell(config_shift_enable) && !$past(i_rst) |-> tick_reg == CHAIN_LEN)
      else $error("shift tick count wrong");
   AST_TICK_SPACING: assert property (
      shift_clk_en && config_shift_enable |=> !shift_clk_en [*3])
      else $error("shift ticks too close");
   AST_LAST_BIT_ONE: assert property (
      shift_clk_en && config_shift_enable && tick_reg == CHAIN_LEN - 1
      |-> serial_config_in)
      else $error("final bit not one");
   AST_DATA_HELD: assert property (
      config_shift_enable && $past(config_shift_enable)
      && !$past(shift_clk_en) |-> $stable(serial_config_in))
      else $error("data moved between ticks");
   AST_UPD_KEEPS_CHAIN: assert property (
      config_update |=> $stable(serial_config_out))
      else $error("update moved chain");
   COV_UPDATE: cover property (config_update);
   COV_SHIFT_END: cover property ($fell(config_shift_enable));
   COV_DYNAMIC: cover property (config_source_dynamic && config_update);
endmodule

// file: verif/tb_pll_serial_config_chain.sv
// self-checking bench: controller and clock block joined by the link
// assumes registers 0x00-0x1c as in the controller, one master, 40 ns clock
`timescale 1ns/1ps
module tb_pll_serial_config_chain;
   import cfg_chain_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic en, dyn, lock, rp, pins;
   logic [6:0] in_div, fb_div;
   logic [1:0] fb_sel;
   logic [4:0] fb_dly;
   logic [2:0] st_sel, vco, dy_sel;
   logic [14:0] out_div;
   logic [8:0] pp_sel;
   logic fb_x;
   logic [24:0] out_dly;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int drops = 0;
   logic [31:0] rd;
   cfg_chain_if link_if();
   clock_cfg_controller clock_cfg_controller_inst (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .link(link_if));
   clock_cfg_block clock_cfg_block_inst (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .link(link_if), .o_block_enabled(en),
      .o_dynamic_mode(dyn), .o_lock_held(lock), .o_input_divider(in_div),
      .o_feedback_divider(fb_div), .o_output_dividers(out_div),
      .o_post_pll_selects(pp_sel), .o_feedback_select(fb_sel),
      .o_feedback_delay(fb_dly), .o_feedback_extra_select(fb_x),
      .o_output_delays(out_dly), .o_static_input_selects(st_sel),
      .o_vco_range_select(vco), .o_dynamic_input_selects(dy_sel),
      .o_reset_permit_bit(rp), .o_secondary_from_pins(pins));
   pll_serial_config_chain_sva pll_serial_config_chain_sva_inst (
      .i_core_clk(i_core_clk), .i_rst(i_rst),
      .shift_clk_en(link_if.shift_clk_en),
      .config_shift_enable(link_if.config_shift_enable),
      .config_update(link_if.config_update),
      .serial_config_in(link_if.serial_config_in),
      .serial_config_out(link_if.serial_config_out),
      .block_power_off_n(link_if.block_power_off_n),
      .config_source_dynamic(link_if.config_source_dynamic));
   always #20 i_core_clk = ~i_core_clk;
   // lock drops counted at the settled half of the cycle
   always @(negedge i_core_clk) begin
      if (lock !== 1'b1) drops++;
   end
   // watchdog: the whole run, two full loads included, needs about 810 cycles
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // one single-word transfer; waits on hready, plus one fixed settle cycle after a write
   task automatic ahb(input logic wr, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge i_core_clk);
      while (hready !== 1'b1) @(posedge i_core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge i_core_clk);
      while (hready !== 1'b1) @(posedge i_core_clk);
      rd = hrdata;
      cmp("hresp", 32'h0, {31'h0, hresp});
      // a write lands at this edge; let it settle before anyone looks
      if (wr) @(posedge i_core_clk);
   endtask
   // applied fields; ignored bits expected cleared
   task automatic chk_fields(input logic [80:0] w);
      w = w & ~SIM_IGNORE_MASK;
      cmp("in_div", w[POS_INPUT_DIV +: 7], in_div);
      cmp("fb_div", w[POS_FEEDBACK_DIV +: 7], fb_div);
      cmp("out_div", w[POS_OUT_DIV_A +: 15], out_div);
      cmp("pp_sel", w[POS_MUX_A +: 9], pp_sel);
      cmp("fb_x", w[POS_FB_EXTRA], fb_x);
      cmp("out_dly", w[POS_GLOBAL_A_DLY +: 25], out_dly);
      cmp("fb_sel", w[POS_FB_SELECT +: 2], fb_sel);
      cmp("fb_dly", w[POS_FB_DELAY +: 5], fb_dly);
      cmp("vco", w[POS_VCO_RANGE +: 3], vco);
      cmp("st_sel", w[POS_STATIC_SEL_A +: 3], st_sel);
      cmp("dy_sel", w[POS_DYN_SEL_A +: 3], dy_sel);
      cmp("rp", w[POS_RESET_PERMIT], rp);
   endtask
   // full load, a second start while busy must be ignored
   task automatic load(input logic [31:0] w0, w1, w2);
      int n;
      ahb(1'b1, 32'h00, w0);
      ahb(1'b1, 32'h04, w1);
      ahb(1'b1, 32'h08, w2);
      ahb(1'b1, 32'h10, 32'h1);
      ahb(1'b1, 32'h10, 32'h1);
      ahb(1'b0, 32'h10, 32'h0);
      cmp("busy", 32'h1, rd & 32'h1);
      for (n = 0; n < 400 && rd[0] !== 1'b0; n++) ahb(1'b0, 32'h10, 32'h0);
      cmp("done", 32'h0, rd & 32'h1);
   endtask
   task automatic t_reset_state();
      cmp("en", 32'h1, en);
      cmp("dyn", 32'h0, dyn);
      chk_fields(NV_DEFAULT_IMAGE);
      ahb(1'b0, 32'h0c, 32'h0);
      cmp("ctrl", 32'h1, rd);
      ahb(1'b1, 32'h40, 32'hffff_ffff);
      ahb(1'b0, 32'h40, 32'h0);
      cmp("unmapped", 32'h0, rd);
   endtask
   task automatic t_loads();
      int d0;
      ahb(1'b1, 32'h0c, 32'h3);
      cmp("dyn", 32'h1, dyn);
      d0 = drops;
      load(32'h1234_5678, 32'h9abc_def0, 32'h0000_5a5a);
      cmp("lock_drop", 32'h1, (drops > d0));
      chk_fields({17'h15a5a, 32'h9abc_def0, 32'h1234_5678});
      cmp("pins", 32'h1, pins);
      d0 = drops;
      load(32'h8765_5678, 32'h0f0f_0f0f, 32'h0001_ffff);
      cmp("lock_kept", 32'h0, (drops > d0));
      chk_fields({17'h1ffff, 32'h0f0f_0f0f, 32'h8765_5678});
      cmp("pins", 32'h0, pins);
      ahb(1'b0, 32'h14, 32'h0);
      cmp("back0", 32'h1234_5678, rd);
      ahb(1'b0, 32'h18, 32'h0);
      cmp("back1", 32'h9abc_def0, rd);
      ahb(1'b0, 32'h1c, 32'h0);
      cmp("back2", 32'h0001_5a5a, rd);
   endtask
   task automatic t_static_power();
      ahb(1'b1, 32'h0c, 32'h1);
      cmp("dyn", 32'h0, dyn);
      chk_fields(NV_DEFAULT_IMAGE);
      ahb(1'b1, 32'h0c, 32'h2);
      cmp("en", 32'h0, en);
      chk_fields(81'h0);
   endtask
   task automatic t_reset_mid_shift();
      ahb(1'b1, 32'h0c, 32'h3);
      ahb(1'b1, 32'h10, 32'h1);
      repeat (100) @(posedge i_core_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      ahb(1'b0, 32'h10, 32'h0);
      cmp("idle", 32'h0, rd & 32'h1);
      chk_fields(NV_DEFAULT_IMAGE);
   endtask
   initial begin
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_reset_state();
      t_loads();
      t_static_power();
      t_reset_mid_shift();
      report_and_stop();
   end
endmodule
